// File: dmrq_pkg.sv
// Purpose: shared constants and types for the dma request and transfer mode controller
// Assumes: four channels, one 100 MHz core clock
// Notes: per-channel control and mode bytes arrive packed side by side on plain ports
package dmrq_pkg;
	localparam int NCH = 4;
	localparam int CH_W = 2;
	localparam int BYTE_W = 8;
	localparam int SRC_LSB = 0;
	localparam int SRC_W = 4;
	localparam int SENSE_BIT = 4;
	localparam int MODE_BIT = 2;
	localparam logic [3:0] SRC_NONE = 4'h0;
	localparam logic [3:0] SRC_EXT = 4'h1;
	localparam logic [3:0] SRC_SW = 4'h2;
	localparam logic [3:0] SRC_PERIPH_FIRST = 4'h3;
	localparam int NPERIPH = 13;
	localparam int FIFO_DEPTH = 16;
	localparam int CMD_W = 4;
	localparam logic [3:0] PIN_IDLE = 4'hf;
	localparam logic [3:0] EN_RESET = 4'h0;
	localparam logic [3:0] FLAG_RESET = 4'h0;
	localparam real CLK_PERIOD_NS = 10.0;
	typedef enum logic [1:0] {
		ST_CPU = 2'b00,
		ST_DMA = 2'b01,
		ST_OTHER = 2'b10,
		ST_GAP = 2'b11
	} dmrq_bus_state_t;
endpackage : dmrq_pkg

// File: dmrq_core.sv
// Purpose: request capture, burst and cycle-steal sequencing and bus yielding for four channels
// Assumes: arbiter requests, peripheral requests and config come from core-clock logic
// Notes: address and count datapath sits outside; it pops one command per transfer unit
`timescale 1ns/100ps

module dmrq_fifo #(
	parameter int WIDTH = 4,
	parameter int DEPTH = 16
) (
	input wire logic clk, // core clock
	input wire logic rst, // async reset, high
	input wire logic in_valid, // push request
	output logic in_ready, // room for a word
	input wire logic [WIDTH-1:0] in_data, // pushed word
	output logic out_valid, // head word present
	input wire logic out_ready, // consumer takes head
	output logic [WIDTH-1:0] out_data // head word
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [CW-1:0] cnt;
		logic ov;
		logic [WIDTH-1:0] od;
	} dmrq_fifo_state_t;
	dmrq_fifo_state_t r_reg, r_next;
	logic take, load;

	// head sits in a register so the consumer sees flop outputs
	assign in_ready = (r_reg.cnt != CW'(DEPTH));
	assign out_valid = r_reg.ov;
	assign out_data = r_reg.od;

	always_comb begin
		r_next = r_reg;
		take = in_valid && in_ready;
		load = (r_reg.cnt != '0) && (!r_reg.ov || out_ready);
		if (take) begin
			r_next.mem[r_reg.wr] = in_data;
			r_next.wr = (r_reg.wr == AW'(DEPTH - 1)) ? '0 : AW'(r_reg.wr + 1'b1);
		end
		if (load) begin
			r_next.od = r_reg.mem[r_reg.rd];
			r_next.ov = 1'b1;
			r_next.rd = (r_reg.rd == AW'(DEPTH - 1)) ? '0 : AW'(r_reg.rd + 1'b1);
		end else if (out_ready) begin
			r_next.ov = 1'b0;
		end
		r_next.cnt = CW'(r_reg.cnt + CW'(take) - CW'(load));
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end
endmodule : dmrq_fifo

// Functional notes
// - sense bit clear selects edge sensing of the request pin
// - falling edge on the request pin sets the channel flag
// - burst edge flag clears on disable, software clear, completion or terminal count
// - accepted burst locks out every other channel until it ends
// - bus order: refresh, hold, dma, then cpu
// - higher master takes bus after current cycle; transfer resumes afterwards
// - four-bit field picks none, pin, software, timers, uarts or converter
// - after burst completion the cpu gets one bus cycle before next request; a terminal count stop gets none
// - level flag follows pin low; pin high stops burst, enable kept
// - pin low again resumes at the next address
// - level flag stays set while pin low even after completion
// - mode bit set selects cycle steal, which needs edge sensing
// - cycle steal clears flag at unit start; bus returns if nothing pending
// - cycle steal re-picks the highest pending channel after every unit
// - cycle steal keeps enable set and continues at next request
// - count zero, and block count zero in array chain, ends and disables
// - new pin edge before cycle end re-sets the flag for continuous transfer
// - a channel is accepted only with flag and enable both set
// - software request pulse sets the flag when software source selected
// - mode bit clear selects burst transfer
// - fixed priority: channel 0 highest down to channel 3
module dmrq_core (
	input wire logic CORE_CLK, // 100 MHz core clock
	input wire logic RST, // async reset, high
	input wire logic [3:0] EXT_XFER_REQUEST_N, // request pins, low active
	input wire logic TERMINAL_COUNT_N, // forced stop pin, low active
	input wire logic [12:0] PERIPH_REQ, // internal source pulses
	input wire logic [31:0] CHANNEL_CONTROL_REG, // byte per channel: source, sense
	input wire logic [31:0] CHANNEL_MODE_LOW_REG, // byte per channel: transfer mode
	input wire logic [3:0] SW_REQ_WR, // software request write pulse
	input wire logic [3:0] ENABLE_SET, // software enable set pulse
	input wire logic [3:0] ENABLE_CLR, // software enable clear pulse
	input wire logic [3:0] FLAG_CLR, // software flag clear pulse
	input wire logic [3:0] COUNT_ZERO, // transfer counter is zero
	input wire logic [3:0] BLOCK_ZERO, // block counter is zero
	input wire logic [3:0] ARRAY_CHAIN, // array chain transfer selected
	input wire logic REFRESH_REQ, // dram refresh wants bus
	input wire logic HOLD_REQ, // external hold wants bus
	input wire logic BUS_CYCLE_END, // current bus cycle ends
	input wire logic XFER_CMD_READY, // datapath takes command
	output logic XFER_CMD_VALID, // command waiting
	output logic [3:0] XFER_CMD_DATA, // {steal, lock, channel}
	output logic [3:0] REQ_FLAG, // channel request flags
	output logic [3:0] ENABLE, // channel enable bits
	output logic [3:0] CHANNEL_DONE, // normal completion pulse
	output logic [1:0] ACTIVE_CHAN, // channel last served
	output logic GRANT_CPU, // cpu owns bus
	output logic GRANT_DMA, // dma owns bus
	output logic GRANT_REFRESH, // refresh owns bus
	output logic GRANT_HOLD // hold owns bus
);
	typedef struct packed {
		logic [3:0] ext_s1;
		logic [3:0] ext_s2;
		logic [3:0] ext_s3;
		logic tc_s1;
		logic tc_s2;
		logic [3:0] flag;
		logic [3:0] en;
		logic [3:0] done;
		dmrq_pkg::dmrq_bus_state_t st;
		logic [1:0] chan;
		logic lock;
		logic g_cpu;
		logic g_dma;
		logic g_ref;
		logic g_hold;
	} dmrq_core_state_t;
	localparam dmrq_core_state_t RESET_STATE = '{
		ext_s1: dmrq_pkg::PIN_IDLE, ext_s2: dmrq_pkg::PIN_IDLE, ext_s3: dmrq_pkg::PIN_IDLE,
		tc_s1: 1'b1, tc_s2: 1'b1, flag: dmrq_pkg::FLAG_RESET, en: dmrq_pkg::EN_RESET,
		done: 4'h0, st: dmrq_pkg::ST_CPU, chan: 2'h0, lock: 1'b0,
		g_cpu: 1'b1, g_dma: 1'b0, g_ref: 1'b0, g_hold: 1'b0};

	dmrq_core_state_t r_reg, r_next;
	logic [3:0] src [dmrq_pkg::NCH];
	logic [3:0] hit, lvl_mode, cs_mode, clr, en_off, accept, avail, cur;
	logic higher, fin, tc_stop, any, start_ok, push, fifo_ready;
	logic [1:0] best;
	logic [3:0] push_data;

	always_comb begin
		for (int i = 0; i < dmrq_pkg::NCH; i++) begin
			src[i] = CHANNEL_CONTROL_REG[i*dmrq_pkg::BYTE_W + dmrq_pkg::SRC_LSB +: dmrq_pkg::SRC_W];
			lvl_mode[i] = CHANNEL_CONTROL_REG[i*dmrq_pkg::BYTE_W + dmrq_pkg::SENSE_BIT]
				&& (src[i] == dmrq_pkg::SRC_EXT);
			cs_mode[i] = CHANNEL_MODE_LOW_REG[i*dmrq_pkg::BYTE_W + dmrq_pkg::MODE_BIT];
			hit[i] = 1'b0;
			if (src[i] == dmrq_pkg::SRC_EXT) begin
				hit[i] = !lvl_mode[i] && r_reg.ext_s3[i] && !r_reg.ext_s2[i];
			end else if (src[i] == dmrq_pkg::SRC_SW) begin
				hit[i] = SW_REQ_WR[i];
			end else if (src[i] != dmrq_pkg::SRC_NONE) begin
				hit[i] = PERIPH_REQ[4'(src[i] - dmrq_pkg::SRC_PERIPH_FIRST)];
			end
		end
	end

	assign accept = r_reg.flag & r_reg.en;
	assign higher = REFRESH_REQ || HOLD_REQ;
	assign cur = 4'(4'h1 << r_reg.chan);
	assign fin = COUNT_ZERO[r_reg.chan] && (!ARRAY_CHAIN[r_reg.chan] || BLOCK_ZERO[r_reg.chan]);
	// terminal count only ends a burst; a stolen unit simply finishes
	assign tc_stop = !r_reg.tc_s2 && !cs_mode[r_reg.chan];

	always_comb begin
		// a locked burst only competes with itself; a finishing channel drops out
		avail = r_reg.lock ? (accept & cur) : accept;
		if (r_reg.st == dmrq_pkg::ST_DMA && BUS_CYCLE_END && (fin || tc_stop)) begin
			avail = r_reg.lock ? 4'h0 : (accept & ~cur);
		end
		any = 1'b0;
		best = 2'h0;
		for (int i = dmrq_pkg::NCH - 1; i >= 0; i--) begin
			if (avail[i]) begin
				any = 1'b1;
				best = 2'(i);
			end
		end
		start_ok = any && fifo_ready && !higher;
	end

	always_comb begin
		r_next = r_reg;
		r_next.ext_s1 = EXT_XFER_REQUEST_N;
		r_next.ext_s2 = r_reg.ext_s1;
		r_next.ext_s3 = r_reg.ext_s2;
		r_next.tc_s1 = TERMINAL_COUNT_N;
		r_next.tc_s2 = r_reg.tc_s1;
		r_next.done = 4'h0;
		clr = FLAG_CLR | ENABLE_CLR;
		en_off = ENABLE_CLR;
		push = 1'b0;
		if (r_reg.lock && !r_reg.en[r_reg.chan]) begin
			r_next.lock = 1'b0;
		end
		case (r_reg.st)
			dmrq_pkg::ST_CPU: begin
				if (higher) begin
					r_next.st = dmrq_pkg::ST_OTHER;
				end else if (start_ok) begin
					push = 1'b1;
				end
			end
			dmrq_pkg::ST_DMA: begin
				if (BUS_CYCLE_END) begin
					r_next.st = dmrq_pkg::ST_CPU;
					if (fin) begin
						en_off[r_reg.chan] = 1'b1;
						r_next.done[r_reg.chan] = 1'b1;
						clr[r_reg.chan] = 1'b1;
						r_next.lock = 1'b0;
					end else if (tc_stop) begin
						clr[r_reg.chan] = 1'b1;
						r_next.lock = 1'b0;
					end
					if (fin && !cs_mode[r_reg.chan]) begin
						r_next.st = dmrq_pkg::ST_GAP;
					end else if (higher && !(fin || tc_stop)) begin
						r_next.st = dmrq_pkg::ST_OTHER;
					end else if (start_ok) begin
						push = 1'b1;
					end
					// a burst whose level request dropped falls back to the cpu, lock kept
				end
			end
			dmrq_pkg::ST_OTHER: begin
				if (!higher) begin
					r_next.st = dmrq_pkg::ST_CPU;
				end
			end
			default: begin
				if (BUS_CYCLE_END) begin
					r_next.st = dmrq_pkg::ST_CPU;
				end
			end
		endcase
		if (push) begin
			r_next.st = dmrq_pkg::ST_DMA;
			r_next.chan = best;
			if (cs_mode[best]) begin
				clr[best] = 1'b1;
			end else begin
				r_next.lock = 1'b1;
			end
		end
		for (int i = 0; i < dmrq_pkg::NCH; i++) begin
			if (lvl_mode[i]) begin
				r_next.flag[i] = !r_reg.ext_s2[i];
			end else begin
				// a fresh request in the clearing cycle is kept
				r_next.flag[i] = (r_reg.flag[i] && !clr[i]) || hit[i];
			end
			r_next.en[i] = (r_reg.en[i] && !en_off[i]) || ENABLE_SET[i];
		end
		r_next.g_dma = (r_next.st == dmrq_pkg::ST_DMA);
		r_next.g_ref = (r_next.st == dmrq_pkg::ST_OTHER) && REFRESH_REQ;
		r_next.g_hold = (r_next.st == dmrq_pkg::ST_OTHER) && !REFRESH_REQ && HOLD_REQ;
		r_next.g_cpu = !(r_next.g_dma || r_next.g_ref || r_next.g_hold);
	end

	assign push_data = {cs_mode[best], !cs_mode[best], best};

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			r_reg <= RESET_STATE;
		end else begin
			r_reg <= r_next;
		end
	end

	// command queue lets the datapath lag; when full no new unit starts
	dmrq_fifo #(.WIDTH(dmrq_pkg::CMD_W), .DEPTH(dmrq_pkg::FIFO_DEPTH)) u_cmd_fifo (
		.clk(CORE_CLK),
		.rst(RST),
		.in_valid(push),
		.in_ready(fifo_ready),
		.in_data(push_data),
		.out_valid(XFER_CMD_VALID),
		.out_ready(XFER_CMD_READY),
		.out_data(XFER_CMD_DATA)
	);

	assign REQ_FLAG = r_reg.flag;
	assign ENABLE = r_reg.en;
	assign CHANNEL_DONE = r_reg.done;
	assign ACTIVE_CHAN = r_reg.chan;
	assign GRANT_CPU = r_reg.g_cpu;
	assign GRANT_DMA = r_reg.g_dma;
	assign GRANT_REFRESH = r_reg.g_ref;
	assign GRANT_HOLD = r_reg.g_hold;

	a_accept_needs_en: assert property (@(posedge CORE_CLK) disable iff (RST)
		push |-> (r_reg.flag[best] && r_reg.en[best]))
		else $error("unit started on a channel without flag and enable");
	a_burst_lock_chan: assert property (@(posedge CORE_CLK) disable iff (RST)
		(push && r_reg.lock) |-> (best == r_reg.chan))
		else $error("locked burst served another channel");
	a_refresh_first: assert property (@(posedge CORE_CLK) disable iff (RST)
		(r_reg.st == dmrq_pkg::ST_CPU && REFRESH_REQ) |=> (GRANT_REFRESH && !GRANT_DMA))
		else $error("refresh not granted first");
	a_yield_keeps_lock: assert property (@(posedge CORE_CLK) disable iff (RST)
		(r_reg.st == dmrq_pkg::ST_DMA && BUS_CYCLE_END && higher && !fin && !tc_stop
		&& r_reg.en[r_reg.chan] && !ENABLE_CLR[r_reg.chan])
		|=> (r_reg.st == dmrq_pkg::ST_OTHER && r_reg.lock == $past(r_reg.lock)))
		else $error("bus not yielded or burst lost on yield");
	a_gap_after_burst: assert property (@(posedge CORE_CLK) disable iff (RST)
		(r_reg.st == dmrq_pkg::ST_DMA && BUS_CYCLE_END && fin && !cs_mode[r_reg.chan])
		|=> GRANT_CPU [*2])
		else $error("cpu not given a bus cycle after burst end");
	a_steal_clears_flag: assert property (@(posedge CORE_CLK) disable iff (RST)
		(push && cs_mode[best] && !hit[best]) |=> !REQ_FLAG[$past(best)])
		else $error("cycle steal flag not cleared at unit start");
	a_done_disables: assert property (@(posedge CORE_CLK) disable iff (RST)
		(r_reg.done != 4'h0) |-> ((r_reg.done & r_reg.en & ~$past(ENABLE_SET)) == 4'h0))
		else $error("enable still set after completion");

	for (genvar g = 0; g < dmrq_pkg::NCH; g++) begin : g_chk
		a_edge_sets_flag: assert property (@(posedge CORE_CLK) disable iff (RST)
			hit[g] |=> REQ_FLAG[g])
			else $error("request edge did not set flag");
		a_level_follows: assert property (@(posedge CORE_CLK) disable iff (RST)
			lvl_mode[g] |=> (REQ_FLAG[g] == !$past(r_reg.ext_s2[g])))
			else $error("level flag does not follow pin");
	end
endmodule : dmrq_core

// File: dmrq_partner.sv
// Purpose: datapath and bus timing model on the far side of the request controller
// Assumes: one core clock, bus cycles of a fixed length set by the bench
// Notes: command intake can be stalled to fill the command fifo
`timescale 1ns/100ps
module dmrq_partner (
	input wire logic clk, // core clock
	input wire logic rst, // async reset, high
	input wire logic [3:0] len, // bus cycle length minus one
	input wire logic stall, // hold off command intake
	input wire logic cmd_valid, // command waiting
	output logic cmd_ready, // head command taken
	output logic cyc_end, // bus cycle end pulse
	output int taken // commands taken so far
);
	logic [3:0] cnt_reg;
	assign cmd_ready = !stall;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_reg <= 4'h0;
			cyc_end <= 1'b0;
			taken <= 0;
		end else begin
			cyc_end <= (cnt_reg == len);
			cnt_reg <= (cnt_reg == len) ? 4'h0 : cnt_reg + 4'h1;
			if (cmd_valid && !stall)
				taken <= taken + 1;
		end
	end
endmodule : dmrq_partner

// File: dmrq_core_tb_top.sv
// Purpose: self-checking bench for the dma request and transfer mode controller
// Assumes: block and array-chain counters tied off, single transfer only
// Notes: waits poll a condition for at most 80 clocks
`timescale 1ns/100ps
module dmrq_core_tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] pin_n = 4'hf;
	logic tc_n = 1'b1;
	logic [12:0] preq = 13'h0;
	logic [31:0] ctl = 32'h0;
	logic [31:0] mode = 32'h0;
	logic [3:0] swr = 4'h0, ens = 4'h0, enc = 4'h0, fclr = 4'h0, cz = 4'h0, len = 4'h3;
	logic refr = 1'b0, hold = 1'b0, stall = 1'b0;
	logic bce, rdy, vld, g_cpu, g_dma, g_ref, g_hold;
	logic [3:0] cmd, flag, en, done;
	logic [1:0] chan;
	int taken, t0;
	int err_count = 0;
	int checked = 0;
	always #5 clk = ~clk;
	dmrq_core u_dmrq_core (.CORE_CLK(clk), .RST(rst), .EXT_XFER_REQUEST_N(pin_n),
		.TERMINAL_COUNT_N(tc_n), .PERIPH_REQ(preq), .CHANNEL_CONTROL_REG(ctl),
		.CHANNEL_MODE_LOW_REG(mode), .SW_REQ_WR(swr), .ENABLE_SET(ens), .ENABLE_CLR(enc),
		.FLAG_CLR(fclr), .COUNT_ZERO(cz), .BLOCK_ZERO(4'h0), .ARRAY_CHAIN(4'h0),
		.REFRESH_REQ(refr), .HOLD_REQ(hold), .BUS_CYCLE_END(bce), .XFER_CMD_READY(rdy),
		.XFER_CMD_VALID(vld), .XFER_CMD_DATA(cmd), .REQ_FLAG(flag), .ENABLE(en),
		.CHANNEL_DONE(done), .ACTIVE_CHAN(chan), .GRANT_CPU(g_cpu), .GRANT_DMA(g_dma),
		.GRANT_REFRESH(g_ref), .GRANT_HOLD(g_hold));
	dmrq_partner u_dmrq_partner (.clk(clk), .rst(rst), .len(len), .stall(stall),
		.cmd_valid(vld), .cmd_ready(rdy), .cyc_end(bce), .taken(taken));
	task automatic cmp(string what, logic [7:0] exp, logic [7:0] got);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp
	task automatic tick(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	// 0 enable set, 1 enable clear, 2 flag clear, other software request
	task automatic pulse(int s, logic [3:0] v);
		@(posedge clk);
		case (s)
			0: ens <= v;
			1: enc <= v;
			2: fclr <= v;
			default: swr <= v;
		endcase
		@(posedge clk);
		{swr, ens, enc, fclr} <= 16'h0;
		#1;
	endtask : pulse
	function automatic logic ok(int s);
		case (s)
			0: return g_dma;
			1: return g_cpu;
			2: return g_ref;
			3: return g_hold;
			default: return done != 4'h0;
		endcase
	endfunction : ok
	task automatic till(int s);
		for (int k = 0; k < 80 && ok(s) !== 1'b1; k++)
			tick(1);
	endtask : till
	task automatic end_sim;
		$display("compares %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_sim
	initial begin
		#100us;
		err_count++;
		end_sim();
	end
	initial begin
		tick(4);
		rst <= 1'b0;
		tick(1);
		cmp("reset en", 8'h0, 8'(en));
		cmp("reset cpu", 8'h1, 8'(g_cpu));
		preq <= 13'h1fff;
		tick(1);
		preq <= 13'h0;
		tick(1);
		cmp("none src", 8'h0, 8'(flag));
		for (int c = 3; c < 16; c++) begin
			ctl <= 32'(c);
			tick(1);
			preq <= 13'(1 << (c - 3));
			tick(1);
			preq <= 13'h0;
			tick(1);
			cmp("periph src", 8'h1, 8'(flag));
			pulse(2, 4'h1);
		end
		// ch0 software, ch1 pin with edge sense
		ctl <= 32'h0000_0102;
		pin_n <= 4'hd;
		tick(6);
		cmp("edge flag", 8'h2, 8'(flag));
		cmp("no enable", 8'h0, 8'(g_dma));
		pin_n <= 4'hf;
		pulse(0, 4'h2);
		till(0);
		cmp("burst chan", 8'h1, 8'(chan));
		pulse(3, 4'h1);
		pulse(0, 4'h1);
		tick(12);
		cmp("burst lock", 8'h1, 8'(chan));
		cz <= 4'h2;
		till(4);
		cz <= 4'h0;
		cmp("done", 8'h2, 8'(done));
		cmp("flag after", 8'h1, 8'(flag));
		cmp("cpu gap", 8'h1, 8'(g_cpu));
		till(0);
		cmp("next chan", 8'h0, 8'(chan));
		refr <= 1'b1;
		hold <= 1'b1;
		till(2);
		cmp("refresh first", 8'h0, 8'(g_hold));
		cmp("refresh grant", 8'h1, 8'(g_ref));
		refr <= 1'b0;
		till(3);
		cmp("hold grant", 8'h0, 8'(g_dma));
		cmp("hold owner", 8'h1, 8'(g_hold));
		hold <= 1'b0;
		till(0);
		cmp("resume", 8'h0, 8'(chan));
		tc_n <= 1'b0;
		till(1);
		tick(2);
		cmp("tc stop", 8'h0, 8'(flag));
		tc_n <= 1'b1;
		refr <= 1'b1;
		tick(2);
		cmp("idle refresh", 8'h1, 8'(g_ref));
		refr <= 1'b0;
		pulse(1, 4'h1);
		// ch2 level sense on a slower bus
		ctl <= 32'h0011_0000;
		len <= 4'h6;
		pulse(0, 4'h4);
		pin_n <= 4'hb;
		till(0);
		cmp("level chan", 8'h2, 8'(chan));
		pin_n <= 4'hf;
		tick(3);
		till(1);
		cmp("level drop", 8'h0, 8'(flag));
		cmp("level en", 8'h4, 8'(en));
		pin_n <= 4'hb;
		till(0);
		cmp("level again", 8'h2, 8'(chan));
		cz <= 4'h4;
		till(4);
		cz <= 4'h0;
		tick(2);
		cmp("level end", 8'h0, 8'(en));
		cmp("level hold", 8'h4, 8'(flag));
		pin_n <= 4'hf;
		// ch3 cycle steal from software, datapath stalled to fill the fifo
		len <= 4'h3;
		ctl <= 32'h0200_0000;
		mode <= 32'h0400_0000;
		stall <= 1'b1;
		t0 = taken;
		// ch2 left level sense with its flag up; drop it so only ch3 shows
		pulse(2, 4'h4);
		pulse(0, 4'h8);
		for (int i = 0; i < 18; i++) begin
			pulse(3, 4'h8);
			till(0);
			cmp("steal clear", 8'h0, 8'(flag & {g_dma, 3'h0}));
			tick(1);
			till(1);
		end
		cmp("steal cmd", 8'h0b, 8'(cmd));
		cmp("fifo full", 8'h8, 8'(flag));
		cmp("steal en", 8'h8, 8'(en));
		cmp("cmd valid", 8'h1, 8'(vld));
		stall <= 1'b0;
		tick(60);
		cmp("units", 8'd18, 8'(taken - t0));
		cmp("cmd drained", 8'h0, 8'(vld));
		end_sim();
	end
endmodule : dmrq_core_tb_top
